//--- rtl/tpseq_params.svh
// Offsets, field positions, reset values and command codes of the packet sequencer.
`ifndef TPSEQ_PARAMS_SVH
`define TPSEQ_PARAMS_SVH
`define TPSEQ_ADDR_STATUS     12'h000
`define TPSEQ_ADDR_COMMAND    12'h004
`define TPSEQ_ADDR_CONFIG     12'h008
`define TPSEQ_ADDR_MASK       12'h00c
`define TPSEQ_ADDR_NODE_ID    12'h010
`define TPSEQ_ADDR_DIAG       12'h014
`define TPSEQ_ADDR_RAM_PTR    12'h018
`define TPSEQ_ADDR_RAM_DATA   12'h01c
`define TPSEQ_CFG_CHAIN_BIT   6
`define TPSEQ_CFG_LONG_BIT    0
`define TPSEQ_CFG_RESET       8'h00
`define TPSEQ_MASK_RESET      8'h00
`define TPSEQ_ST_TA_BIT       0
`define TPSEQ_ST_TMA_BIT      1
`define TPSEQ_ST_TTA_BIT      2
`define TPSEQ_ST_RI_BIT       3
`define TPSEQ_ST_TRI_BIT      4
`define TPSEQ_ST_EXC_BIT      5
`define TPSEQ_CMD_TX_EN       4'h3
`define TPSEQ_CMD_RX_EN       4'h4
`define TPSEQ_CMD_TX_DIS      4'h1
`define TPSEQ_CMD_RX_DIS      4'h2
`define TPSEQ_CMD_CLR_TX      4'h5
`define TPSEQ_CMD_CLR_RX      4'h6
`define TPSEQ_PAGE_SHIFT      9
`define TPSEQ_HALF_OFFSET     11'h100
`define TPSEQ_SRC_BYTE        11'h000
`define TPSEQ_DST_BYTE        11'h001
`define TPSEQ_CNT_BYTE        11'h002
`define TPSEQ_LCNT_BYTE       11'h003
`define TPSEQ_NAK_LIMIT       8'h80
`endif

//--- rtl/tpseq_pkg.sv
// Types shared by the packet sequencer.
package tpseq_pkg;
  typedef struct packed {
    logic [1:0] page;
    logic       half;
  } tpseq_page_t;

  typedef struct packed {
    logic       valid;
    logic       ack;
    logic       nak;
    logic       none;
  } tpseq_reply_t;

  typedef enum logic [5:0] {
    TPSEQ_IDLE  = 6'b000001,
    TPSEQ_WAIT  = 6'b000010,
    TPSEQ_QUERY = 6'b000100,
    TPSEQ_FETCH = 6'b001000,
    TPSEQ_SEND  = 6'b010000,
    TPSEQ_DONE  = 6'b100000
  } tpseq_tx_state_t;
endpackage

//--- rtl/tpseq_top.sv
// Transmit and receive packet sequencer with packet RAM, command queues and APB registers.
// Function
// - With long packets enabled, buffer byte 2 zero means long, else short.
// - Byte 0 holds source node, byte 1 destination node of the page.
// - Short count byte 2 is 256-N; long has byte 2 zero, byte 3 512-N.
// - On transmit the device writes its own node id into byte 0.
// - Transmit enable only while available; it clears available and acknowledged flags.
// - Non-broadcast packets are preceded by a buffer query to the destination.
// - Positive query answer sends packet; packet ack sets acked and available.
// - Refused query passes the token and repeats at next token.
// - Receiver answers buffer query with refusal while receiver inhibited.
// - Excessive refusals set a diagnostic flag raising a maskable interrupt.
// - Transmit disable abandons at next token, sets available, acked stays clear.
// - No reply to query sets available, acked stays clear.
// - A garbled query reply does not pass the token onward.
// - Transmit completion interrupts only when its mask bit allows.
// - Receive enable clears receiver inhibited and selects the target page.
// - Receiver inhibited interrupts only when its mask bit is set.
// - Received packets keep sender layout; good storage sets receiver inhibited.
// - Chaining is off after reset, on when configuration bit 6 is one.
// - Chaining queues two transmit and two receive commands plus their statuses.
// - In chaining, masks act on done edge flags set only at completion.
// - In chaining, available and inhibited flags still show live state.
// - Page offset bit adds 256 bytes to the 512-byte page base.
// - Only clear-transmit-interrupt clears the transmit done flag and interrupt.
// - Only clear-receive-interrupt clears receive done; a second one waits.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "tpseq_params.svh"
module tpseq_top (
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_SRST,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_token,
  input  wire logic        i_query_in,
  input  wire logic        i_rx_valid,
  input  wire logic [7:0]  i_rx_byte,
  input  wire logic        i_rx_last,
  input  wire logic        i_rx_good,
  input  wire tpseq_pkg::tpseq_reply_t i_reply,
  output logic             o_pass_token,
  output logic             o_query_send,
  output logic [7:0]       o_query_dest,
  output logic             o_query_reply_ack,
  output logic             o_query_reply_nak,
  output logic             o_tx_valid,
  output logic [7:0]       o_tx_byte,
  output logic             o_tx_last,
  output logic             o_irq
);
  logic [7:0]  ram [0:2047];
  logic [7:0]  config_reg;
  logic [7:0]  mask_reg;
  logic [7:0]  node_id;
  logic [10:0] ram_ptr;
  logic        ta_flag;
  logic        tma_flag;
  logic        ri_flag;
  logic        exc_flag;
  logic [1:0]  tta_cnt;
  logic [1:0]  tri_cnt;
  logic [1:0]  tma_hist;
  logic [1:0]  txq_cnt;
  logic [1:0]  rxq_cnt;
  tpseq_pkg::tpseq_page_t txq [0:1];
  tpseq_pkg::tpseq_page_t rxq [0:1];
  tpseq_pkg::tpseq_tx_state_t tx_state;
  logic [7:0]  nak_cnt;
  logic [10:0] tx_base;
  logic [10:0] tx_idx;
  logic [10:0] tx_end;
  logic        tx_abort;
  logic [10:0] rx_idx;
  logic        rx_busy;
  logic        wr_acc;
  logic        rd_acc;
  logic [3:0]  cmd;
  logic        chain;
  logic        long_en;
  logic        cmd_tx_en;
  logic        cmd_rx_en;
  logic        cmd_tx_dis;
  logic        cmd_rx_dis;
  logic        cmd_clr_tx;
  logic        cmd_clr_rx;
  logic        tx_finish;
  logic        tx_ok;
  logic        rx_finish;
  logic [7:0]  status;
  logic [10:0] rx_base;
  logic [7:0]  cnt_short;
  logic [10:0] next_tx_end;

  // Page base address from page number and half-page offset bit.
  function automatic logic [10:0] page_base(input tpseq_pkg::tpseq_page_t p);
    page_base = (11'(p.page) << `TPSEQ_PAGE_SHIFT) + (p.half ? `TPSEQ_HALF_OFFSET : 11'h000);
  endfunction

  assign wr_acc     = i_psel && i_penable && i_pwrite;
  assign rd_acc     = i_psel && !i_penable && !i_pwrite;
  assign cmd        = i_pwdata[3:0];
  assign chain      = config_reg[`TPSEQ_CFG_CHAIN_BIT];
  assign long_en    = config_reg[`TPSEQ_CFG_LONG_BIT];
  assign cmd_tx_en  = wr_acc && i_paddr == `TPSEQ_ADDR_COMMAND && cmd == `TPSEQ_CMD_TX_EN;
  assign cmd_rx_en  = wr_acc && i_paddr == `TPSEQ_ADDR_COMMAND && cmd == `TPSEQ_CMD_RX_EN;
  assign cmd_tx_dis = wr_acc && i_paddr == `TPSEQ_ADDR_COMMAND && cmd == `TPSEQ_CMD_TX_DIS;
  assign cmd_rx_dis = wr_acc && i_paddr == `TPSEQ_ADDR_COMMAND && cmd == `TPSEQ_CMD_RX_DIS;
  assign cmd_clr_tx = wr_acc && i_paddr == `TPSEQ_ADDR_COMMAND && cmd == `TPSEQ_CMD_CLR_TX;
  assign cmd_clr_rx = wr_acc && i_paddr == `TPSEQ_ADDR_COMMAND && cmd == `TPSEQ_CMD_CLR_RX;
  assign rx_base    = page_base(rxq[0]);
  assign cnt_short  = ram[tx_base + `TPSEQ_CNT_BYTE];
  // Frame length from count byte 2; with long packets enabled a zero count byte marks a long packet.
  assign next_tx_end = (long_en && cnt_short == 8'h00) ? tx_base + 11'h200 - 11'h001
                                                       : tx_base + 11'h100 - 11'h001;
  assign tx_finish  = tx_state == tpseq_pkg::TPSEQ_DONE;
  assign tx_ok      = tx_finish && !tx_abort;
  assign rx_finish  = i_rx_valid && i_rx_last && rxq_cnt != 2'd0;

  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      config_reg <= `TPSEQ_CFG_RESET;
      mask_reg   <= `TPSEQ_MASK_RESET;
      node_id    <= 8'h00;
      ram_ptr    <= 11'h000;
    end else if (wr_acc) begin
      unique case (i_paddr)
        `TPSEQ_ADDR_CONFIG:   config_reg <= i_pwdata[7:0];
        `TPSEQ_ADDR_MASK:     mask_reg <= i_pwdata[7:0];
        `TPSEQ_ADDR_NODE_ID:  node_id <= i_pwdata[7:0];
        `TPSEQ_ADDR_RAM_PTR:  ram_ptr <= i_pwdata[10:0];
        `TPSEQ_ADDR_RAM_DATA: ram_ptr <= ram_ptr + 11'h001;
        default:              ram_ptr <= ram_ptr;
      endcase
    end else if (rd_acc && i_paddr == `TPSEQ_ADDR_RAM_DATA) begin
      ram_ptr <= ram_ptr + 11'h001;
    end
  end

  // Packet RAM: host writes, received bytes, and the local source id on transmit.
  always_ff @(posedge I_SYS_CLK) begin
    if (wr_acc && i_paddr == `TPSEQ_ADDR_RAM_DATA) begin
      ram[ram_ptr] <= i_pwdata[7:0];
    end else if (tx_state == tpseq_pkg::TPSEQ_FETCH) begin
      ram[tx_base + `TPSEQ_SRC_BYTE] <= node_id;
    end else if (i_rx_valid && rxq_cnt != 2'd0) begin
      ram[rx_base + rx_idx] <= i_rx_byte;
    end
  end

  // Transmit command queue; outside chaining it is one deep.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      txq_cnt <= 2'd0;
      txq[0]  <= '0;
      txq[1]  <= '0;
    end else begin
      if (tx_finish) begin
        txq[0] <= txq[1];
      end
      if (cmd_tx_en && (txq_cnt == 2'd0 || (tx_finish && txq_cnt == 2'd1))) begin
        txq[0] <= i_pwdata[6:4];
      end else if (cmd_tx_en && chain && txq_cnt != 2'd0) begin
        txq[tx_finish ? 1'b0 : 1'b1] <= i_pwdata[6:4];
      end
      if (cmd_tx_en && (ta_flag || (chain && txq_cnt == 2'd1)) && !tx_finish) begin
        txq_cnt <= txq_cnt + 2'd1;
      end else if (tx_finish && !(cmd_tx_en && chain)) begin
        txq_cnt <= txq_cnt - 2'd1;
      end
    end
  end

  // Transmit sequence: query, then fetch and send, with refusal and abort outcomes.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      tx_state     <= tpseq_pkg::TPSEQ_IDLE;
      tx_abort     <= 1'b0;
      tx_base      <= 11'h000;
      tx_idx       <= 11'h000;
      tx_end       <= 11'h000;
      nak_cnt      <= 8'h00;
      o_pass_token <= 1'b0;
      o_query_send <= 1'b0;
      o_query_dest <= 8'h00;
      o_tx_valid   <= 1'b0;
      o_tx_byte    <= 8'h00;
      o_tx_last    <= 1'b0;
    end else begin
      o_pass_token <= 1'b0;
      o_query_send <= 1'b0;
      o_tx_valid   <= 1'b0;
      o_tx_last    <= 1'b0;
      if (cmd_tx_dis && txq_cnt != 2'd0) begin
        tx_abort <= 1'b1;
      end
      unique case (tx_state)
        tpseq_pkg::TPSEQ_IDLE: begin
          if (txq_cnt != 2'd0) begin
            tx_base  <= page_base(txq[0]);
            tx_state <= tpseq_pkg::TPSEQ_WAIT;
          end
        end
        tpseq_pkg::TPSEQ_WAIT: begin
          if (i_token) begin
            if (tx_abort) begin
              tx_state <= tpseq_pkg::TPSEQ_DONE;
            end else if (ram[tx_base + `TPSEQ_DST_BYTE] == 8'h00) begin
              tx_state <= tpseq_pkg::TPSEQ_FETCH;
            end else begin
              o_query_send <= 1'b1;
              o_query_dest <= ram[tx_base + `TPSEQ_DST_BYTE];
              tx_state     <= tpseq_pkg::TPSEQ_QUERY;
            end
          end
        end
        tpseq_pkg::TPSEQ_QUERY: begin
          if (i_reply.valid) begin
            if (i_reply.ack) begin
              tx_state <= tpseq_pkg::TPSEQ_FETCH;
            end else if (i_reply.nak) begin
              o_pass_token <= 1'b1;
              if (nak_cnt != `TPSEQ_NAK_LIMIT) begin
                nak_cnt <= nak_cnt + 8'h01;
              end
              tx_state <= tpseq_pkg::TPSEQ_WAIT;
            end else if (i_reply.none) begin
              tx_abort <= 1'b1;
              tx_state <= tpseq_pkg::TPSEQ_DONE;
            end else begin
              tx_state <= tpseq_pkg::TPSEQ_WAIT;
            end
          end
        end
        tpseq_pkg::TPSEQ_FETCH: begin
          tx_idx   <= tx_base;
          tx_end   <= next_tx_end;
          tx_state <= tpseq_pkg::TPSEQ_SEND;
        end
        tpseq_pkg::TPSEQ_SEND: begin
          if (o_tx_last) begin
            if (i_reply.valid) begin
              tx_abort <= !i_reply.ack;
              tx_state <= tpseq_pkg::TPSEQ_DONE;
            end else begin
              o_tx_last <= 1'b1;
            end
          end else begin
            o_tx_valid <= 1'b1;
            o_tx_byte  <= ram[tx_idx];
            o_tx_last  <= tx_idx == tx_end;
            tx_idx     <= tx_idx + 11'h001;
          end
        end
        tpseq_pkg::TPSEQ_DONE: begin
          o_pass_token <= 1'b1;
          tx_abort     <= 1'b0;
          nak_cnt      <= 8'h00;
          tx_state     <= tpseq_pkg::TPSEQ_IDLE;
        end
      endcase
    end
  end

  // Transmit flags; the acknowledged history is double buffered for chaining.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      ta_flag  <= 1'b1;
      tma_flag <= 1'b0;
      tta_cnt  <= 2'd0;
      tma_hist <= 2'b00;
      exc_flag <= 1'b0;
    end else begin
      if (tx_finish) begin
        ta_flag  <= txq_cnt == 2'd1 && !cmd_tx_en;
        tma_flag <= tx_ok;
      end else if (cmd_tx_en) begin
        ta_flag  <= 1'b0;
        tma_flag <= 1'b0;
      end
      if (chain && tx_finish && tta_cnt != 2'd2) begin
        tma_hist[tta_cnt[0]] <= tx_ok;
        tta_cnt <= tta_cnt + 2'd1;
      end else if (cmd_clr_tx && tta_cnt != 2'd0 && !tx_finish) begin
        tma_hist[0] <= tma_hist[1];
        tta_cnt <= tta_cnt - 2'd1;
      end
      if (tx_state == tpseq_pkg::TPSEQ_QUERY && i_reply.valid && !i_reply.ack && i_reply.nak &&
          nak_cnt == `TPSEQ_NAK_LIMIT - 8'h01) begin
        exc_flag <= 1'b1;
      end else if (wr_acc && i_paddr == `TPSEQ_ADDR_DIAG) begin
        exc_flag <= 1'b0;
      end
    end
  end

  // Receive queue and flags.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      rxq_cnt <= 2'd0;
      rxq[0]  <= '0;
      rxq[1]  <= '0;
      ri_flag <= 1'b1;
      tri_cnt <= 2'd0;
      rx_idx  <= 11'h000;
      rx_busy <= 1'b0;
    end else begin
      if (i_rx_valid && rxq_cnt != 2'd0) begin
        rx_busy <= !i_rx_last;
        rx_idx  <= i_rx_last ? 11'h000 : rx_idx + 11'h001;
      end
      if (rx_finish) begin
        rxq[0]  <= rxq[1];
        rxq_cnt <= rxq_cnt - 2'd1;
        ri_flag <= i_rx_good ? rxq_cnt == 2'd1 : ri_flag;
      end else if (cmd_rx_en && (rxq_cnt == 2'd0 || (chain && rxq_cnt == 2'd1))) begin
        rxq[rxq_cnt[0]] <= i_pwdata[6:4];
        rxq_cnt <= rxq_cnt + 2'd1;
        ri_flag <= 1'b0;
      end else if (cmd_rx_dis && rxq_cnt != 2'd0 && !rx_busy) begin
        rxq[0]  <= rxq[1];
        rxq_cnt <= rxq_cnt - 2'd1;
        ri_flag <= rxq_cnt == 2'd1;
      end
      if (chain && rx_finish && i_rx_good && tri_cnt != 2'd2) begin
        tri_cnt <= tri_cnt + 2'd1;
      end else if (cmd_clr_rx && tri_cnt != 2'd0) begin
        tri_cnt <= tri_cnt - 2'd1;
      end
    end
  end

  // Buffer query answers from this node acting as receiver.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_query_reply_ack <= 1'b0;
      o_query_reply_nak <= 1'b0;
    end else begin
      o_query_reply_ack <= i_query_in && !ri_flag;
      o_query_reply_nak <= i_query_in && ri_flag;
    end
  end

  assign status = {2'b00, exc_flag, chain ? tri_cnt != 2'd0 : ri_flag, ri_flag,
                   tta_cnt != 2'd0, chain ? tma_hist[0] : tma_flag, ta_flag};

  // Interrupt: chaining masks the edge flags, otherwise the live flags.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= (mask_reg[`TPSEQ_ST_TA_BIT] && (chain ? tta_cnt != 2'd0 : ta_flag)) ||
               (mask_reg[`TPSEQ_ST_RI_BIT] && (chain ? tri_cnt != 2'd0 : ri_flag)) ||
               (mask_reg[`TPSEQ_ST_EXC_BIT] && exc_flag);
    end
  end

  // APB slave: zero wait states, unmapped addresses read zero with an error.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          `TPSEQ_ADDR_STATUS:   o_prdata <= {24'h0, status};
          `TPSEQ_ADDR_COMMAND:  o_prdata <= 32'h0;
          `TPSEQ_ADDR_CONFIG:   o_prdata <= {24'h0, config_reg};
          `TPSEQ_ADDR_MASK:     o_prdata <= {24'h0, mask_reg};
          `TPSEQ_ADDR_NODE_ID:  o_prdata <= {24'h0, node_id};
          `TPSEQ_ADDR_DIAG:     o_prdata <= {24'h0, nak_cnt};
          `TPSEQ_ADDR_RAM_PTR:  o_prdata <= {21'h0, ram_ptr};
          `TPSEQ_ADDR_RAM_DATA: o_prdata <= {24'h0, ram[ram_ptr]};
          default: begin
            o_prdata  <= 32'h0;
            o_pslverr <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

//--- dv/tpseq_chk.sv
// Concurrent checks on the packet sequencer's ports.
`timescale 1ns/1ns
`include "tpseq_params.svh"
module tpseq_chk (
  input wire logic                    I_SYS_CLK,
  input wire logic                    I_SRST,
  input wire logic                    i_psel,
  input wire logic                    i_penable,
  input wire logic                    i_pwrite,
  input wire logic [11:0]             i_paddr,
  input wire logic [31:0]             i_pwdata,
  input wire logic                    o_pready,
  input wire logic                    o_pslverr,
  input wire logic                    i_query_in,
  input wire tpseq_pkg::tpseq_reply_t i_reply,
  input wire logic                    o_pass_token,
  input wire logic                    o_query_send,
  input wire logic                    o_query_reply_ack,
  input wire logic                    o_query_reply_nak,
  input wire logic                    o_tx_valid,
  input wire logic                    o_tx_last,
  input wire logic                    o_irq
);
  logic       q_out;
  logic       granted;
  logic [7:0] irq_mask;
  default clocking @(posedge I_SYS_CLK); endclocking
  default disable iff (I_SRST);
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) q_out <= 1'b0;
    else if (o_query_send) q_out <= 1'b1;
    else if (i_reply.valid) q_out <= 1'b0;
  end
  // A frame is only legal after our own query was granted.
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) granted <= 1'b0;
    else if (q_out && i_reply.valid && i_reply.ack) granted <= 1'b1;
    else if (o_tx_last) granted <= 1'b0;
  end
  always_ff @(posedge I_SYS_CLK) begin
    if (I_SRST) irq_mask <= 8'h00;
    else if (i_psel && i_penable && i_pwrite && o_pready && i_paddr == `TPSEQ_ADDR_MASK)
      irq_mask <= i_pwdata[7:0];
  end
  sequence s_granted;
    q_out && i_reply.valid && i_reply.ack;
  endsequence
  sequence s_refused;
    q_out && i_reply.valid && i_reply.nak;
  endsequence
  sequence s_garbled;
    q_out && i_reply.valid && !i_reply.ack && !i_reply.nak && !i_reply.none;
  endsequence
  a_setup_ready: assert property (i_psel && !i_penable |=> o_pready)
    else $error("pready missing after setup");
  a_err_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_tx_granted: assert property (o_tx_valid |-> granted)
    else $error("frame byte without a granted query");
  a_ack_sends: assert property (s_granted |-> ##[1:5] o_tx_valid)
    else $error("granted query did not start the frame");
  a_frame_done: assert property (!q_out && !granted && i_reply.valid |-> ##[1:3] o_pass_token)
    else $error("frame reply did not end the transfer");
  a_nak_passes: assert property (s_refused |-> ##[1:3] o_pass_token)
    else $error("refused query did not pass the token");
  a_one_answer: assert property (i_query_in |=> o_query_reply_ack != o_query_reply_nak)
    else $error("query answer missing or doubled");
  a_silent_done: assert property (q_out && i_reply.valid && i_reply.none |-> ##[1:3] o_pass_token)
    else $error("silent destination did not end the transfer");
  a_garbled_holds: assert property (s_garbled |=> !o_pass_token [*4])
    else $error("token passed after a garbled reply");
  a_mask_blocks: assert property (irq_mask == 8'h00 && $past(irq_mask, 2) == 8'h00 |-> !o_irq)
    else $error("interrupt with all mask bits clear");
endmodule

//--- dv/tpseq_net_model.sv
// Remote node model: answers queries and frames, and sends frames to the sequencer.
`timescale 1ns/1ns
module tpseq_net_model (
  input  wire logic               i_clk,
  input  wire logic [1:0]         i_mode,
  input  wire logic               i_pkt_ack,
  input  wire logic               i_query_send,
  input  wire logic               i_tx_last,
  output tpseq_pkg::tpseq_reply_t o_reply,
  output logic                    o_rx_valid,
  output logic [7:0]              o_rx_byte,
  output logic                    o_rx_last,
  output logic                    o_rx_good
);
  integer     seed = 77815;
  logic [7:0] pkt [256];
  initial begin
    o_reply = 4'h0;
    o_rx_valid = 1'b0;
    o_rx_byte = 8'h00;
    o_rx_last = 1'b0;
    o_rx_good = 1'b0;
  end
  // A random delay of one to four cycles gives both prompt and slow answers.
  always @(posedge i_clk) begin
    if (i_query_send || i_tx_last) begin : answer
      logic frame;
      frame = i_tx_last;
      repeat (1 + ($unsigned($random(seed)) % 4)) @(posedge i_clk);
      o_reply <= frame ? {1'b1, i_pkt_ack, 1'b0, !i_pkt_ack}
                       : {1'b1, i_mode == 2'h0, i_mode == 2'h1, i_mode == 2'h2};
      @(posedge i_clk);
      o_reply <= {1'b0, 3'($random(seed))};
    end
  end
  task automatic send_rx(input logic [7:0] dst);
    int n;
    n = 1 + ($unsigned($random(seed)) % 253);
    for (int i = 0; i < 256; i++) pkt[i] = 8'($random(seed));
    pkt[1] = dst;
    pkt[2] = 8'(256 - n);
    for (int i = 0; i < 256; i++) begin
      @(posedge i_clk);
      o_rx_valid <= 1'b1;
      o_rx_byte <= pkt[i];
      o_rx_last <= (i == 255);
      o_rx_good <= (i == 255);
    end
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_last <= 1'b0;
    o_rx_good <= 1'b0;
    o_rx_byte <= ~o_rx_byte;
  endtask
endmodule

//--- dv/tpseq_tb_top.sv
// Self-checking bench for the packet sequencer.
`timescale 1ns/1ns
`include "tpseq_params.svh"
module tpseq_tb_top;
  typedef struct packed {
    logic        err;
    logic [31:0] msk;
    logic [31:0] val;
  } tpseq_exp_t;
  logic        clk, srst, i_psel, i_penable, i_pwrite, i_token, i_query_in, pkt_ack;
  logic        o_pready, o_pslverr, i_rx_valid, i_rx_last, i_rx_good, o_pass_token, o_query_send;
  logic        o_query_reply_ack, o_query_reply_nak, o_tx_valid, o_tx_last, o_irq;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata;
  logic [1:0]  mode;
  logic [7:0]  node, i_rx_byte, o_query_dest, o_tx_byte;
  logic [7:0]  tm [256];
  tpseq_pkg::tpseq_reply_t i_reply;
  tpseq_exp_t  rdq [$];
  logic [7:0]  txq [$];
  logic        rq [$];
  integer      seed = 77815, n_errors = 0, total_checks = 0, cyc = 0, n;
  tpseq_top dut (.I_SYS_CLK(clk), .I_SRST(srst), .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_token, .i_query_in, .i_rx_valid, .i_rx_byte, .i_rx_last,
    .i_rx_good, .i_reply, .o_pass_token, .o_query_send, .o_query_dest, .o_query_reply_ack,
    .o_query_reply_nak, .o_tx_valid, .o_tx_byte, .o_tx_last, .o_irq);
  tpseq_net_model u_net (.i_clk(clk), .i_mode(mode), .i_pkt_ack(pkt_ack), .i_query_send(o_query_send),
    .i_tx_last(o_tx_last), .o_reply(i_reply), .o_rx_valid(i_rx_valid), .o_rx_byte(i_rx_byte),
    .o_rx_last(i_rx_last), .o_rx_good(i_rx_good));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic print_verdict;
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // The hang limit sits far above the few thousand cycles the sequence needs.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  always @(posedge clk) begin
    if (i_psel && i_penable && o_pready && !i_pwrite && rdq.size() > 0) begin
      check({o_pslverr, o_prdata & rdq[0].msk}, {rdq[0].err, rdq[0].val});
      void'(rdq.pop_front());
    end
    if (o_tx_valid && txq.size() > 0) begin
      check({24'h0, o_tx_last, o_tx_byte}, {24'h0, txq.size() == 1, txq[0]});
      void'(txq.pop_front());
    end
    if (o_query_send) check({25'h0, o_query_dest}, {25'h0, tm[1]});
    if ((o_query_reply_ack || o_query_reply_nak) && rq.size() > 0) check({32'h0, o_query_reply_nak}, {32'h0, rq.pop_front()});
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge clk);
    i_penable <= 1'b1;
    @(posedge clk);
    while (o_pready !== 1'b1) @(posedge clk);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e, input logic er = 1'b0);
    rdq.push_back({er, m, e});
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] pg);
    apb(1'b1, `TPSEQ_ADDR_COMMAND, {25'h0, pg, c});
  endtask
  task automatic tk;
    @(posedge clk);
    i_token <= 1'b1;
    @(posedge clk);
    i_token <= 1'b0;
  endtask
  task automatic wpass;
    @(posedge clk);
    while (o_pass_token !== 1'b1) @(posedge clk);
  endtask
  task automatic txrun(input logic [1:0] m, input logic pa);
    mode <= m;
    pkt_ack <= pa;
    tk();
    wpass();
  endtask
  task automatic txexp;
    for (int i = 0; i < 256; i++) txq.push_back(i == 0 ? node : tm[i]);
  endtask
  task automatic qry(input logic nak);
    rq.push_back(nak);
    @(posedge clk);
    i_query_in <= 1'b1;
    @(posedge clk);
    i_query_in <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic irqck(input logic e);
    repeat (3) @(posedge clk);
    check({32'h0, o_irq}, {32'h0, e});
  endtask
  initial begin
    {i_psel, i_penable, i_pwrite, i_token, i_query_in, pkt_ack} = 6'h0;
    i_paddr = 12'h0;
    i_pwdata = 32'h0;
    mode = 2'h0;
    srst = 1'b1;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rd(`TPSEQ_ADDR_STATUS, 32'h0b, 32'h09);
    rd(`TPSEQ_ADDR_CONFIG, 32'hff, 32'h00);
    rd(12'h020, 32'hffffffff, 32'h0, 1'b1);
    node = 8'($random(seed)) | 8'h01;
    apb(1'b1, `TPSEQ_ADDR_NODE_ID, {24'h0, node});
    n = 1 + ($unsigned($random(seed)) % 253);
    apb(1'b1, `TPSEQ_ADDR_RAM_PTR, 32'h300);
    for (int i = 0; i < 256; i++) begin
      tm[i] = (i == 0) ? 8'hff : (i == 2) ? 8'(256 - n) : 8'($random(seed)) | 8'(i == 1);
      apb(1'b1, `TPSEQ_ADDR_RAM_DATA, {24'h0, tm[i]});
    end
    cmd(`TPSEQ_CMD_TX_EN, 3'h3);
    rd(`TPSEQ_ADDR_STATUS, 32'h0b, 32'h08);
    txrun(2'h1, 1'b1);
    txexp();
    txrun(2'h0, 1'b1);
    rd(`TPSEQ_ADDR_STATUS, 32'h0b, 32'h0b);
    cmd(`TPSEQ_CMD_TX_EN, 3'h3);
    txrun(2'h2, 1'b1);
    rd(`TPSEQ_ADDR_STATUS, 32'h0b, 32'h09);
    cmd(`TPSEQ_CMD_TX_EN, 3'h3);
    mode <= 2'h3;
    tk();
    repeat (8) @(posedge clk);
    rd(`TPSEQ_ADDR_STATUS, 32'h01, 32'h00);
    cmd(`TPSEQ_CMD_TX_DIS, 3'h0);
    tk();
    wpass();
    rd(`TPSEQ_ADDR_STATUS, 32'h0b, 32'h09);
    cmd(`TPSEQ_CMD_TX_EN, 3'h3);
    repeat (128) txrun(2'h1, 1'b1);
    rd(`TPSEQ_ADDR_STATUS, 32'h20, 32'h20);
    apb(1'b1, `TPSEQ_ADDR_MASK, 32'h20);
    irqck(1'b1);
    apb(1'b1, `TPSEQ_ADDR_DIAG, 32'h0);
    irqck(1'b0);
    apb(1'b1, `TPSEQ_ADDR_MASK, 32'h0);
    cmd(`TPSEQ_CMD_TX_DIS, 3'h0);
    tk();
    wpass();
    qry(1'b1);
    apb(1'b1, `TPSEQ_ADDR_MASK, 32'h08);
    irqck(1'b1);
    cmd(`TPSEQ_CMD_RX_EN, 3'h4);
    irqck(1'b0);
    rd(`TPSEQ_ADDR_STATUS, 32'h08, 32'h00);
    qry(1'b0);
    u_net.send_rx(node);
    rd(`TPSEQ_ADDR_STATUS, 32'h08, 32'h08);
    irqck(1'b1);
    apb(1'b1, `TPSEQ_ADDR_RAM_PTR, 32'h400);
    for (int i = 0; i < 256; i++) rd(`TPSEQ_ADDR_RAM_DATA, 32'hff, {24'h0, u_net.pkt[i]});
    apb(1'b1, `TPSEQ_ADDR_MASK, 32'h0);
    apb(1'b1, `TPSEQ_ADDR_CONFIG, 32'h40);
    rd(`TPSEQ_ADDR_CONFIG, 32'hff, 32'h40);
    apb(1'b1, `TPSEQ_ADDR_MASK, 32'h01);
    cmd(`TPSEQ_CMD_TX_EN, 3'h3);
    cmd(`TPSEQ_CMD_TX_EN, 3'h3);
    txexp();
    txrun(2'h0, 1'b1);
    irqck(1'b1);
    txexp();
    txrun(2'h0, 1'b0);
    rd(`TPSEQ_ADDR_STATUS, 32'h07, 32'h07);
    cmd(`TPSEQ_CMD_CLR_TX, 3'h0);
    rd(`TPSEQ_ADDR_STATUS, 32'h07, 32'h05);
    cmd(`TPSEQ_CMD_CLR_TX, 3'h0);
    rd(`TPSEQ_ADDR_STATUS, 32'h07, 32'h01);
    irqck(1'b0);
    print_verdict();
  end
endmodule
bind tpseq_top tpseq_chk u_chk (.I_SYS_CLK, .I_SRST, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .o_pready, .o_pslverr, .i_query_in, .i_reply, .o_pass_token, .o_query_send, .o_query_reply_ack,
  .o_query_reply_nak, .o_tx_valid, .o_tx_last, .o_irq);
